// file: rtl/gcp_pkg.sv
// Constants, field layouts and types for the gauge control register block.
// Assumes one 50 MHz system clock; all pins are sampled into that domain.
package gcp_pkg;

  // ==========================================================================
  // Register map and serial addresses
  localparam logic [7:0] CTRL_ADDR = 8'h01;
  localparam logic [7:0] ACC_MSB_ADDR = 8'h02;
  localparam logic [7:0] ACC_LSB_ADDR = 8'h03;
  localparam logic [7:0] CTRL_RST = 8'h3c;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h64; // Arbitrary default, set per board
  localparam logic [6:0] ARA_ADDR = 7'h0c;     // SMBus alert response address

  // ==========================================================================
  // Control register fields
  localparam logic [1:0] MODE_AUTO = 2'h3;
  localparam logic [1:0] MODE_SCAN = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] PIN_ALERT = 2'h2;
  localparam logic [1:0] PIN_CHG_DONE = 2'h1;
  localparam logic [1:0] PIN_OFF = 2'h0;
  localparam logic [2:0] PRESC_MAX_CODE = 3'h6;

  typedef struct packed {
    logic [1:0] mode;    // Converter mode
    logic [2:0] presc;   // Prescale exponent
    logic [1:0] pin_cfg; // Dual function pin setup
    logic shdn;          // Analog shutdown
  } gcp_ctrl_t;

  // Limit crossing events from the comparators
  typedef struct packed {
    logic charge_hi;
    logic charge_lo;
    logic volt;
    logic curr;
    logic temp;
  } gcp_lim_t;

  // ==========================================================================
  // Charge accumulator and timing
  localparam logic [15:0] ACC_MID = 16'h7fff;
  localparam logic [15:0] ACC_FULL = 16'hffff;
  localparam logic [15:0] ACC_EMPTY = 16'h0000;
  localparam logic [1:0] CONV_LAST = 2'h2; // Voltage, current, temperature
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SCAN_PERIOD_MS = 10_000;
  localparam int unsigned SCAN_CYCLES = SCAN_PERIOD_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    CV_IDLE = 3'b001,
    CV_RUN = 3'b010,
    CV_WAIT = 3'b100
  } gcp_conv_t;

  typedef enum logic [5:0] {
    SI_IDLE = 6'b000001,
    SI_ADDR = 6'b000010,
    SI_PTR = 6'b000100,
    SI_WDAT = 6'b001000,
    SI_RD = 6'b010000,
    SI_ARA = 6'b100000
  } gcp_ser_t;

  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

endpackage : gcp_pkg

// file: rtl/gcp_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes the inputs are slow levels; no multi-bit coherence is promised.
`timescale 1ns/1ps
`default_nettype none
module gcp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_i,           // System clock
  input wire logic sys_rst_i,       // Async reset, high
  input wire logic [W-1:0] d_i,     // Raw pin levels
  output logic [W-1:0] q_o          // Synchronised levels
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ==========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule : gcp_sync
`default_nettype wire

// file: rtl/gcp_gauge_ctrl.sv
// Gauge control register, converter sequencer, charge prescaler and pin logic.
// Assumes SCL/SDA and the dual-function pin arrive asynchronously; analog
// events (integrator steps, conversion done, limit hits) are on clk_i.
`timescale 1ns/1ps
`default_nettype none
module gcp_gauge_ctrl #(
  parameter logic [6:0] DEV_ADDR = gcp_pkg::DEV_ADDR_DEF,
  parameter int unsigned SCAN_CYCLES = gcp_pkg::SCAN_CYCLES
) (
  input wire logic clk_i,                             // 50 MHz clock
  input wire logic sys_rst_i,                         // Async reset, high
  input wire logic scl_i,                             // Serial clock pin
  input wire logic sda_i,                             // Serial data pin level
  output logic sda_o,                                 // Serial data drive value
  output logic sda_oe_o,                              // Serial data pull low
  input wire logic alert_or_charge_done_pin_i,        // Pin level
  output logic alert_or_charge_done_pin_o,            // Pin drive value
  output logic alert_or_charge_done_pin_oe_o,         // Pin pull low
  input wire logic integ_up_i,                        // Integrator up event
  input wire logic integ_dn_i,                        // Integrator down event
  input wire logic conv_done_i,                       // One conversion finished
  input wire gcp_pkg::gcp_lim_t lim_evt_i,            // Limit crossing pulses
  output logic conv_run_o,                            // Converter awake
  output logic analog_on_o,                           // Analog section powered
  output logic [15:0] charge_accumulator_o,           // Accumulated charge
  output gcp_pkg::gcp_ctrl_t ctrl_o                   // Control register
);
  gcp_pkg::gcp_ctrl_t ctrl_q;
  gcp_pkg::gcp_conv_t cv_q;
  gcp_pkg::gcp_ser_t si_q;
  logic [2:0] pins_s;
  logic scl_s, sda_s, pin_s, scl_prev_q, sda_prev_q;
  logic [1:0] conv_cnt_q;
  logic [31:0] tmr_q;
  logic [11:0] presc_cnt_q;
  logic [15:0] acc_q;
  logic alert_q;
  logic [7:0] shreg_q, tx_q, ptr_q;
  logic [3:0] bit_q;
  logic mack_q, rx_ack_q, sda_oe_q;

  // ==========================================================================
  // Pin synchronisers
  gcp_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i({scl_i, sda_i, alert_or_charge_done_pin_i}),
    .q_o(pins_s)
  );
  assign scl_s = pins_s[2];
  assign sda_s = pins_s[1];
  assign pin_s = pins_s[0];

  // ==========================================================================
  // Serial bus decode
  logic scl_rise, scl_fall, start_c, stop_c, byte_end, ack_end, rx_state;
  logic addr_me, addr_ara, wr_ctrl, ara_done;
  logic [7:0] rd_data;
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_c = scl_s & sda_prev_q & ~sda_s;
  assign stop_c = scl_s & ~sda_prev_q & sda_s;
  assign byte_end = scl_fall & (bit_q == gcp_pkg::BIT_LAST);
  assign ack_end = scl_fall & (bit_q == gcp_pkg::BIT_ACK);
  assign rx_state = (si_q == gcp_pkg::SI_ADDR) | (si_q == gcp_pkg::SI_PTR) | (si_q == gcp_pkg::SI_WDAT);
  assign addr_me = shreg_q[7:1] == DEV_ADDR;
  // Answer the alert response read only while holding an alert
  assign addr_ara = (shreg_q[7:1] == gcp_pkg::ARA_ADDR) & shreg_q[0] & alert_q;
  assign wr_ctrl = byte_end & (si_q == gcp_pkg::SI_WDAT) & (ptr_q == gcp_pkg::CTRL_ADDR);
  assign ara_done = ack_end & (si_q == gcp_pkg::SI_ARA) & ~rx_ack_q;

  // Read mux, unmapped pointers read as zero
  assign rd_data = (ptr_q == gcp_pkg::CTRL_ADDR) ? ctrl_q :
                   (ptr_q == gcp_pkg::ACC_MSB_ADDR) ? acc_q[15:8] :
                   (ptr_q == gcp_pkg::ACC_LSB_ADDR) ? acc_q[7:0] : gcp_pkg::UNMAPPED_RD;

  // Line history for edge and start/stop detection
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Byte engine; keeps running in shutdown so the host can wake the part
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      si_q <= gcp_pkg::SI_IDLE;
      bit_q <= '0;
      shreg_q <= '0;
      tx_q <= '0;
      ptr_q <= '0;
      mack_q <= 1'b0;
      rx_ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_c) begin
      si_q <= gcp_pkg::SI_ADDR;
      bit_q <= '1; // The start's own SCL fall wraps this to zero before the first bit
      sda_oe_q <= 1'b0;
    end else if (stop_c) begin
      si_q <= gcp_pkg::SI_IDLE;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (bit_q != gcp_pkg::BIT_ACK) begin
        shreg_q <= {shreg_q[6:0], sda_s};
      end else begin
        mack_q <= ~sda_s;
      end
    end else if (scl_fall && si_q != gcp_pkg::SI_IDLE) begin
      if (byte_end) begin
        bit_q <= gcp_pkg::BIT_ACK;
        sda_oe_q <= 1'b0;
        rx_ack_q <= rx_state;
        if (si_q == gcp_pkg::SI_ADDR) begin
          sda_oe_q <= addr_me | addr_ara;
          si_q <= addr_ara ? gcp_pkg::SI_ARA : ~addr_me ? gcp_pkg::SI_IDLE :
                  shreg_q[0] ? gcp_pkg::SI_RD : gcp_pkg::SI_PTR;
        end else if (si_q == gcp_pkg::SI_PTR) begin
          sda_oe_q <= 1'b1;
          ptr_q <= shreg_q;
          si_q <= gcp_pkg::SI_WDAT;
        end else if (si_q == gcp_pkg::SI_WDAT) begin
          sda_oe_q <= 1'b1;
          ptr_q <= ptr_q + 8'h01;
        end
      end else if (ack_end) begin
        bit_q <= '0;
        rx_ack_q <= 1'b0;
        sda_oe_q <= 1'b0;
        if (si_q == gcp_pkg::SI_ARA && rx_ack_q) begin
          tx_q <= {DEV_ADDR, 1'b0};
          sda_oe_q <= ~DEV_ADDR[6];
        end else if (si_q == gcp_pkg::SI_ARA) begin
          si_q <= gcp_pkg::SI_IDLE;
        end else if (si_q == gcp_pkg::SI_RD && (rx_ack_q || mack_q)) begin
          tx_q <= rd_data;
          sda_oe_q <= ~rd_data[7];
          ptr_q <= ptr_q + 8'h01;
        end else if (si_q == gcp_pkg::SI_RD) begin
          si_q <= gcp_pkg::SI_IDLE;
        end
      end else begin
        bit_q <= bit_q + 4'h1;
        if (!rx_state) begin
          tx_q <= {tx_q[6:0], 1'b0};
          sda_oe_q <= ~tx_q[6];
        end
      end
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;

  // ==========================================================================
  // Converter sequencer
  logic set_end, clr_mode;
  assign set_end = (cv_q == gcp_pkg::CV_RUN) & conv_done_i & (conv_cnt_q == gcp_pkg::CONV_LAST);
  assign clr_mode = set_end & ~ctrl_q.shdn & (ctrl_q.mode == gcp_pkg::MODE_SINGLE);

  // Mode is only looked at between sets, so a rewrite waits for the set to end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cv_q <= gcp_pkg::CV_IDLE;
      conv_cnt_q <= '0;
      tmr_q <= '0;
    end else begin
      case (cv_q)
        gcp_pkg::CV_IDLE: begin
          conv_cnt_q <= '0;
          if (ctrl_q.mode != gcp_pkg::MODE_SLEEP && !ctrl_q.shdn) begin
            cv_q <= gcp_pkg::CV_RUN;
          end
        end
        gcp_pkg::CV_RUN: begin
          if (ctrl_q.shdn) begin
            cv_q <= gcp_pkg::CV_IDLE;
          end else if (set_end) begin
            conv_cnt_q <= '0;
            tmr_q <= '0;
            if (ctrl_q.mode == gcp_pkg::MODE_SCAN) begin
              cv_q <= gcp_pkg::CV_WAIT;
            end else if (ctrl_q.mode != gcp_pkg::MODE_AUTO) begin
              cv_q <= gcp_pkg::CV_IDLE;
            end
          end else if (conv_done_i) begin
            conv_cnt_q <= conv_cnt_q + 2'h1;
          end
        end
        gcp_pkg::CV_WAIT: begin
          if (ctrl_q.shdn || ctrl_q.mode != gcp_pkg::MODE_SCAN) begin
            cv_q <= gcp_pkg::CV_IDLE;
          end else if (tmr_q == 32'(SCAN_CYCLES - 1)) begin
            cv_q <= gcp_pkg::CV_RUN;
          end else begin
            tmr_q <= tmr_q + 32'h1;
          end
        end
        default: cv_q <= gcp_pkg::CV_IDLE;
      endcase
    end
  end
  assign conv_run_o = cv_q == gcp_pkg::CV_RUN;
  assign analog_on_o = ~ctrl_q.shdn;

  // ==========================================================================
  // Control register; a host write beats the self clear of the mode field
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= gcp_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= shreg_q;
    end else if (clr_mode) begin
      ctrl_q.mode <= gcp_pkg::MODE_SLEEP;
    end
  end
  assign ctrl_o = ctrl_q;

  // ==========================================================================
  // Prescaler and charge accumulator
  logic [2:0] presc_eff;
  logic [11:0] m_max;
  logic step_up, step_dn, acc_wrap, chg_full, alert_evt;
  assign presc_eff = (ctrl_q.presc > gcp_pkg::PRESC_MAX_CODE) ? gcp_pkg::PRESC_MAX_CODE : ctrl_q.presc;
  assign m_max = 12'((13'h1 << {presc_eff, 1'b0}) - 13'h1);
  assign step_up = integ_up_i & ~ctrl_q.shdn & (presc_cnt_q == m_max);
  assign step_dn = integ_dn_i & ~ctrl_q.shdn & (presc_cnt_q == '0);
  assign acc_wrap = (step_up & (acc_q == gcp_pkg::ACC_FULL)) | (step_dn & (acc_q == gcp_pkg::ACC_EMPTY));
  assign chg_full = (ctrl_q.pin_cfg == gcp_pkg::PIN_CHG_DONE) & ~pin_s;

  // Residue is zeroed in shutdown; a smaller M can leave it above the new top
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      presc_cnt_q <= '0;
    end else if (ctrl_q.shdn) begin
      presc_cnt_q <= '0;
    end else if (integ_up_i) begin
      presc_cnt_q <= (presc_cnt_q >= m_max) ? 12'h000 : presc_cnt_q + 12'h001;
    end else if (integ_dn_i) begin
      presc_cnt_q <= (presc_cnt_q == '0 || presc_cnt_q > m_max) ? m_max : presc_cnt_q - 12'h001;
    end
  end

  // Charge-complete load wins over counting; wrap rolls over
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_q <= gcp_pkg::ACC_MID;
    end else if (chg_full) begin
      acc_q <= gcp_pkg::ACC_FULL;
    end else if (step_up) begin
      acc_q <= acc_q + 16'h0001;
    end else if (step_dn) begin
      acc_q <= acc_q - 16'h0001;
    end
  end
  assign charge_accumulator_o = acc_q;

  // ==========================================================================
  // Alert latch; a new event in the release cycle keeps the pin low
  assign alert_evt = (ctrl_q.pin_cfg == gcp_pkg::PIN_ALERT) & ((|lim_evt_i) | acc_wrap);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alert_q <= 1'b0;
    end else if (alert_evt) begin
      alert_q <= 1'b1;
    end else if (ara_done) begin
      alert_q <= 1'b0;
    end
  end
  assign alert_or_charge_done_pin_o = 1'b0;
  assign alert_or_charge_done_pin_oe_o = alert_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_set_end;
    cv_q == gcp_pkg::CV_RUN && conv_done_i && conv_cnt_q == gcp_pkg::CONV_LAST && !ctrl_q.shdn;
  endsequence

  a_single_clear: assert property (s_set_end ##0 (ctrl_q.mode == gcp_pkg::MODE_SINGLE && !wr_ctrl)
    |=> ctrl_q.mode == gcp_pkg::MODE_SLEEP && cv_q == gcp_pkg::CV_IDLE) else $error("single mode not cleared");
  a_set_finish: assert property (cv_q == gcp_pkg::CV_RUN && !conv_done_i && !ctrl_q.shdn
    |=> cv_q == gcp_pkg::CV_RUN) else $error("conversion set cut short");
  a_scan_wait: assert property (s_set_end ##0 ctrl_q.mode == gcp_pkg::MODE_SCAN
    |=> cv_q == gcp_pkg::CV_WAIT && tmr_q == '0) else $error("scan mode did not wait");
  a_presc_cap: assert property (ctrl_q.presc >= gcp_pkg::PRESC_MAX_CODE |-> m_max == 12'hfff)
    else $error("prescale cap wrong");
  a_acc_step: assert property (step_up && !chg_full |=> acc_q == $past(acc_q) + 16'h0001)
    else $error("accumulator did not step");
  a_wrap_alert: assert property (acc_wrap && ctrl_q.pin_cfg == gcp_pkg::PIN_ALERT
    |=> alert_q && alert_or_charge_done_pin_oe_o) else $error("wrap did not raise alert");
  a_alert_hold: assert property (alert_q && !ara_done |=> alert_q) else $error("alert dropped early");
  a_ara_release: assert property (ara_done && !alert_evt |=> !alert_or_charge_done_pin_oe_o)
    else $error("alert not released");
  a_pin_idle: assert property (!alert_q |-> !alert_or_charge_done_pin_oe_o) else $error("pin driven idle");
  a_chg_full: assert property (chg_full |=> acc_q == gcp_pkg::ACC_FULL) else $error("full load missed");
  a_shdn_hold: assert property (ctrl_q.shdn && !chg_full |=> $stable(acc_q) && presc_cnt_q == '0)
    else $error("counting in shutdown");
  a_shdn_analog: assert property (ctrl_q.shdn && !wr_ctrl |=> !analog_on_o && cv_q != gcp_pkg::CV_RUN)
    else $error("analog on in shutdown");
  a_shdn_regs: assert property (ctrl_q.shdn && !wr_ctrl |=> $stable(ctrl_q))
    else $error("control lost in shutdown");
endmodule : gcp_gauge_ctrl
`default_nettype wire

// file: dv/gcp_host_model.sv
// Far side of the gauge block: an I2C host driving SCL and SDA, and a charger
// that can pull the dual-function pin low. Both wires have pull-ups.
// Assumes the bench calls the tasks 1 ns after a rising clk_i edge; each step
// lasts 40 ns, so phase to the 20 ns system clock is kept.
`timescale 1ns/1ps
`default_nettype none
module gcp_host_model (
  input wire logic sda_oe_i,  // Device pulls SDA low
  input wire logic pin_oe_i,  // Device pulls the pin low
  output logic scl_o,         // Serial clock, high and still when idle
  output logic sda_o,         // Resolved SDA wire
  output logic pin_o          // Resolved pin wire
);
  logic host_low;
  logic chg_low;

  // ==========================================================================
  // Wires: pulled up, low while any party pulls
  assign sda_o = ~(host_low | sda_oe_i);
  assign pin_o = ~(pin_oe_i | chg_low);

  // Idle bus, charger not signalling
  initial begin
    scl_o = 1'b1;
    host_low = 1'b0;
    chg_low = 1'b0;
  end

  // ==========================================================================
  // Charger pulls the pin low while the battery reads full
  task automatic charger(input logic low);
    chg_low = low;
  endtask : charger

  // Start or repeated start: SDA falls while SCL is high
  task automatic start;
    host_low = 1'b0;
    #40 scl_o = 1'b1;
    #40 host_low = 1'b1;
    #40 scl_o = 1'b0;
    #40;
  endtask : start

  // Stop: SDA rises while SCL is high, then the bus rests
  task automatic stop;
    host_low = 1'b1;
    #40 scl_o = 1'b1;
    #40 host_low = 1'b0;
    #40;
  endtask : stop

  // One bit: data set while SCL is low, sampled in the middle of SCL high
  task automatic bit_io(input logic b, output logic got);
    host_low = ~b;
    #40 scl_o = 1'b1;
    #40 got = sda_o;
    #40 scl_o = 0;
    #40;
  endtask : bit_io

  // Eight bits MSB first and the ninth; send 8'hff to read, ack9 1 to release
  task automatic byte_io(input logic [7:0] tx, input logic ack9, output logic [7:0] rx, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack9, g);
    ack = ~g;
    host_low = 1'b0;
  endtask : byte_io
endmodule : gcp_host_model
`default_nettype wire

// file: dv/gcp_gauge_ctrl_bench.sv
// Self-checking bench for the gauge control block and its alert pin.
// Assumes gcp_pkg and gcp_host_model are compiled first; scan wait shortened.
`timescale 1ns/1ps
`default_nettype none
module gcp_gauge_ctrl_bench;
  localparam int unsigned SCAN = 50;
  localparam logic [6:0] ADDR = gcp_pkg::DEV_ADDR_DEF;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic integ_up_i = 1'b0;
  logic integ_dn_i = 1'b0;
  logic conv_done_i = 1'b0;
  gcp_pkg::gcp_lim_t lim = '0;
  logic scl, sda, sda_oe, pin, pin_oe, conv_run, analog_on, sda_val, pin_val;
  logic [15:0] acc;
  gcp_pkg::gcp_ctrl_t ctrl;
  int error_cnt = 0;
  int compares = 0;

  // ==========================================================================
  // Design, far side and clock
  gcp_gauge_ctrl #(.DEV_ADDR(ADDR), .SCAN_CYCLES(SCAN)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_val), .sda_oe_o(sda_oe), .alert_or_charge_done_pin_i(pin),
    .alert_or_charge_done_pin_o(pin_val), .alert_or_charge_done_pin_oe_o(pin_oe), .integ_up_i(integ_up_i),
    .integ_dn_i(integ_dn_i), .conv_done_i(conv_done_i), .lim_evt_i(lim), .conv_run_o(conv_run),
    .analog_on_o(analog_on), .charge_accumulator_o(acc), .ctrl_o(ctrl));
  gcp_host_model host (.sda_oe_i(sda_oe), .pin_oe_i(pin_oe), .scl_o(scl), .sda_o(sda), .pin_o(pin));
  always #10 clk_i = ~clk_i;

  // ==========================================================================
  // Shared helpers
  task automatic finish_test;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // Pulse kind: 4 integrator up, 2 integrator down, 1 conversion done
  task automatic pulse(input logic [2:0] kind, input int n);
    repeat (n) begin
      {integ_up_i, integ_dn_i, conv_done_i} = kind;
      tick(1);
      {integ_up_i, integ_dn_i, conv_done_i} = 3'h0;
      tick(1);
    end
    tick(2);
  endtask : pulse

  // Control writes below only ever use pin codes 00, 01 and 10
  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] data);
    logic [7:0] r;
    logic a;
    host.start();
    host.byte_io({ADDR, 1'b0}, 1'b1, r, a);
    check(a, 1'b1);
    host.byte_io(ptr, 1'b1, r, a);
    host.byte_io(data, 1'b1, r, a);
    check(a, 1'b1);
    host.stop();
    tick(1);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] r;
    logic a;
    host.start();
    host.byte_io({ADDR, 1'b0}, 1'b1, r, a);
    host.byte_io(ptr, 1'b1, r, a);
    host.start();
    host.byte_io({ADDR, 1'b1}, 1'b1, r, a);
    check(a, 1'b1);
    host.byte_io(8'hff, 1'b1, d, a);
    host.stop();
    tick(1);
  endtask : reg_rd

  // Alert response read: device answers with its own address, pin released
  task automatic ara;
    logic [7:0] r;
    logic a;
    host.start();
    host.byte_io(8'h19, 1'b1, r, a);
    check(a, 1'b1);
    host.byte_io(8'hff, 1'b1, r, a);
    check(r, {ADDR, 1'b0});
    host.stop();
    tick(5);
    check(pin_oe, 1'b0);
  endtask : ara

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] d;
    check(ctrl, 8'h3c);
    check({sda_val, pin_val}, 2'h0);
    check(analog_on, 1'b1);
    check(pin_oe, 1'b0);
    check(conv_run, 1'b0);
    reg_rd(8'h01, d);
    check(d, 8'h3c);
    reg_rd(8'h10, d);
    check(d, 8'h00);
  endtask : t_reset

  task automatic t_presc;
    int m;
    logic [15:0] a0;
    for (int c = 0; c < 8; c++) begin
      m = (c >= 6) ? 4096 : (1 << (2 * c));
      reg_wr(8'h01, {2'h0, c[2:0], gcp_pkg::PIN_OFF, 1'b0});
      a0 = acc;
      pulse(3'h4, m - 1);
      check(acc, a0);
      pulse(3'h4, 1);
      check(acc, a0 + 16'h1);
    end
    pulse(3'h2, 1);
    check(acc, a0);
  endtask : t_presc

  task automatic t_shdn;
    logic [7:0] d;
    logic [15:0] a0;
    a0 = acc;
    reg_wr(8'h01, 8'h09);
    check(analog_on, 1'b0);
    pulse(3'h4, 5);
    check(acc, a0);
    reg_rd(8'h01, d);
    check(d, 8'h09);
    reg_wr(8'h01, 8'h08);
    pulse(3'h4, 3);
    check(acc, a0);
    pulse(3'h4, 1);
    check(acc, a0 + 16'h1);
  endtask : t_shdn

  task automatic t_conv;
    reg_wr(8'h01, {gcp_pkg::MODE_AUTO, 6'h00});
    tick(3);
    check(conv_run, 1'b1);
    pulse(3'h1, 3);
    check(conv_run, 1'b1);
    pulse(3'h1, 1);
    reg_wr(8'h01, {gcp_pkg::MODE_SCAN, 6'h00});
    check(conv_run, 1'b1);
    pulse(3'h1, 2);
    tick(20);
    check(conv_run, 1'b0);
    tick(SCAN);
    check(conv_run, 1'b1);
    reg_wr(8'h01, {gcp_pkg::MODE_SLEEP, 6'h00});
    pulse(3'h1, 3);
    check(conv_run, 1'b0);
    reg_wr(8'h01, {gcp_pkg::MODE_SINGLE, 6'h00});
    tick(3);
    check(conv_run, 1'b1);
    pulse(3'h1, 3);
    check(conv_run, 1'b0);
    check(ctrl.mode, gcp_pkg::MODE_SLEEP);
  endtask : t_conv

  task automatic t_alert;
    for (int i = 0; i < 6; i++) begin
      reg_wr(8'h01, {5'h00, (i == 5) ? gcp_pkg::PIN_OFF : gcp_pkg::PIN_ALERT, 1'b0});
      lim = gcp_pkg::gcp_lim_t'(5'h10 >> (i % 5));
      tick(1);
      lim = '0;
      tick(3);
      check(pin_oe, i != 5);
      if (i == 0) reg_wr(8'h01, 8'h00);
      if (i == 0) check(pin_oe, 1'b1);
      if (i != 5) ara();
    end
  endtask : t_alert

  task automatic t_chg;
    logic [7:0] d;
    reg_wr(8'h01, {5'h00, gcp_pkg::PIN_CHG_DONE, 1'b0});
    host.charger(1'b1);
    tick(6);
    check(acc, 16'hffff);
    check(pin_oe, 1'b0);
    // Full scale must also show through the serial read path
    reg_rd(8'h02, d);
    check(d, 8'hff);
    reg_rd(8'h03, d);
    check(d, 8'hff);
    host.charger(1'b0);
    tick(4);
    reg_wr(8'h01, {5'h00, gcp_pkg::PIN_ALERT, 1'b0});
    pulse(3'h4, 1);
    check(acc, 16'h0000);
    check(pin_oe, 1'b1);
    ara();
  endtask : t_chg

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    tick(4);
    t_reset();
    t_presc();
    t_shdn();
    t_conv();
    t_alert();
    t_chg();
    finish_test();
  end

  // About 0.55 ms of traffic expected; a hang is cut off at 75k cycles
  initial begin
    #1_500_000;
    error_cnt++;
    finish_test();
  end
endmodule : gcp_gauge_ctrl_bench
`default_nettype wire
